// ---- logic/cws_pkg.sv ----
package cws_pkg;

  // ****************************************************************
  // Widths and vectors
  // ****************************************************************
  localparam int CWS_PC_W = 13;
  localparam int CWS_WORD_W = 14;
  localparam int CWS_IMPL_AW = 12;
  localparam int CWS_IMPL_DEPTH = 4096;
  localparam int CWS_ADDR_W = 14;
  localparam logic [12:0] CWS_RESET_VEC = 13'h0000;
  localparam logic [12:0] CWS_IRQ_VEC = 13'h0004;
  localparam logic [12:0] CWS_PC_STEP = 13'h0001;
  localparam logic [11:0] CWS_LOAD_STEP = 12'h001;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int CWS_PROG_SPACE_BIT = 13;
  localparam logic [13:0] CWS_CTRL_ADDR = 14'h2000;
  localparam logic [13:0] CWS_STATUS_ADDR = 14'h2001;
  localparam logic [13:0] CWS_LOAD_ADDR_ADDR = 14'h2002;
  localparam logic [13:0] CWS_LOAD_DATA_ADDR = 14'h2003;
  localparam logic [13:0] CAL_WORD_VOLT_AMP_OFFSET_ADDR = 14'h2087;
  localparam logic [13:0] CAL_WORD_SPAN_AND_GAIN_ADDR = 14'h2088;
  localparam logic [13:0] CAL_WORD_REFERENCE_SPANS_ADDR = 14'h2089;
  localparam logic [13:0] CAL_WORD_REGULATOR_AND_BUFFER_ADDR = 14'h208a;
  localparam logic [13:0] CAL_WORD_CURRENT_AMP_OFFSET_ADDR = 14'h208b;

  // ****************************************************************
  // Calibration field masks and erased value
  // ****************************************************************
  localparam logic [13:0] CWS_MASK_VOLT_AMP_OFFSET = 14'h007f;
  localparam logic [13:0] CWS_MASK_SPAN_AND_GAIN = 14'h1f0f;
  localparam logic [13:0] CWS_MASK_REFERENCE_SPANS = 14'h1f1f;
  localparam logic [13:0] CWS_MASK_REGULATOR_AND_BUFFER = 14'h0fff;
  localparam logic [13:0] CWS_MASK_CURRENT_AMP_OFFSET = 14'h007f;
  localparam logic [13:0] CWS_CAL_ERASED = 14'h3fff;

  // ****************************************************************
  // Control and status fields
  // ****************************************************************
  localparam int CWS_CTRL_HOLD_BIT = 0;
  localparam int CWS_CTRL_RESTART_BIT = 1;
  localparam int CWS_STAT_WRAP_BIT = 13;
  localparam logic CWS_HOLD_RESET = 1'b0;
  localparam logic [11:0] CWS_LOAD_ADDR_RESET = 12'h000;
  localparam logic [13:0] CWS_ZERO_WORD = 14'h0000;

  typedef enum logic [1:0] {
    CWS_ST_BOOT,
    CWS_ST_RUN,
    CWS_ST_HOLD
  } cws_fsm_t;

  typedef struct packed {
    logic [12:0] pc;
    logic [13:0] word;
  } cws_fetch_t;

endpackage

// ---- logic/cws_cal_rom.sv ----
`timescale 1ns/1ps
module cws_cal_rom
  import cws_pkg::*;
#(
  parameter logic [13:0] WORD8 = CWS_CAL_ERASED,
  parameter logic [13:0] WORD9 = CWS_CAL_ERASED,
  parameter logic [13:0] WORD10 = CWS_CAL_ERASED,
  parameter logic [13:0] WORD11 = CWS_CAL_ERASED,
  parameter logic [13:0] WORD12 = CWS_CAL_ERASED
)
(
  input wire logic [13:0] addr,
  output logic [13:0] word,
  output logic hit
);

  // Unimplemented bits are forced low here, whatever the factory image holds.
  always_comb
  begin
    word = CWS_ZERO_WORD;
    hit = 1'b1;
    case (addr)
      CAL_WORD_VOLT_AMP_OFFSET_ADDR: word = WORD8 & CWS_MASK_VOLT_AMP_OFFSET;
      CAL_WORD_SPAN_AND_GAIN_ADDR: word = WORD9 & CWS_MASK_SPAN_AND_GAIN;
      CAL_WORD_REFERENCE_SPANS_ADDR: word = WORD10 & CWS_MASK_REFERENCE_SPANS;
      CAL_WORD_REGULATOR_AND_BUFFER_ADDR: word = WORD11 & CWS_MASK_REGULATOR_AND_BUFFER;
      CAL_WORD_CURRENT_AMP_OFFSET_ADDR: word = WORD12 & CWS_MASK_CURRENT_AMP_OFFSET;
      default: hit = 1'b0;
    endcase
  end

endmodule

// ---- logic/cws_prog_mem.sv ----
`timescale 1ns/1ps
module cws_prog_mem
  import cws_pkg::*;
#(
  parameter int DEPTH = CWS_IMPL_DEPTH,
  parameter int WIDTH = CWS_WORD_W,
  parameter int AW = CWS_IMPL_AW
)
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] fetch_addr,
  output logic [WIDTH-1:0] fetch_word,
  input wire logic [AW-1:0] data_addr,
  output logic [WIDTH-1:0] data_word
);

  // One word per address; the array is not reset, like the flash it stands for.
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Two independent read ports keep table reads off the fetch path.
  assign fetch_word = mem[fetch_addr];
  assign data_word = mem[data_addr];

endmodule

// ---- logic/cws_top.sv ----
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module cws_top
  import cws_pkg::*;
#(
  parameter logic [13:0] CAL_WORD8 = CWS_CAL_ERASED,
  parameter logic [13:0] CAL_WORD9 = CWS_CAL_ERASED,
  parameter logic [13:0] CAL_WORD10 = CWS_CAL_ERASED,
  parameter logic [13:0] CAL_WORD11 = CWS_CAL_ERASED,
  parameter logic [13:0] CAL_WORD12 = CWS_CAL_ERASED,
  parameter int DEPTH = CWS_IMPL_DEPTH
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] reg_addr,
  input wire logic [13:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [13:0] reg_rdata,
  input wire logic fetch_req,
  input wire logic irq_take,
  input wire logic jump_req,
  input wire logic [12:0] jump_target,
  output cws_fetch_t fetch_out,
  output logic fetch_valid,
  output logic [12:0] pc_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [13:0] rdata_reg;
  logic [13:0] rdata_next;
  cws_fetch_t fetch_reg;
  logic fetch_valid_reg;
  logic [12:0] pc_reg;
  logic [12:0] pc_next;
  logic hold_reg;
  logic wrap_reg;
  logic [11:0] load_addr_reg;
  cws_fsm_t state_reg;
  cws_fsm_t state_next;
  logic restart_pulse;
  logic wrap_clear;
  logic load_wr;
  logic fetch_go;
  logic [13:0] cal_word;
  logic cal_hit;
  logic [13:0] imem_word;
  logic [13:0] dmem_word;
  logic [11:0] fetch_index;
  logic [11:0] data_index;
  logic in_prog_space;

  // ****************************************************************
  // Write decode
  // ****************************************************************
  // Calibration words and the program space are read-only from the bus.
  assign restart_pulse = reg_wr && (reg_addr == CWS_CTRL_ADDR)
    && reg_wdata[CWS_CTRL_RESTART_BIT];
  assign wrap_clear = reg_wr && (reg_addr == CWS_STATUS_ADDR)
    && reg_wdata[CWS_STAT_WRAP_BIT];
  assign load_wr = reg_wr && (reg_addr == CWS_LOAD_DATA_ADDR);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hold_reg <= CWS_HOLD_RESET;
    end
    else if (reg_wr && (reg_addr == CWS_CTRL_ADDR))
    begin
      hold_reg <= reg_wdata[CWS_CTRL_HOLD_BIT];
    end
  end

  // The load pointer steps after each data write so a whole image streams in.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      load_addr_reg <= CWS_LOAD_ADDR_RESET;
    end
    else if (reg_wr && (reg_addr == CWS_LOAD_ADDR_ADDR))
    begin
      load_addr_reg <= reg_wdata[CWS_IMPL_AW-1:0];
    end
    else if (load_wr)
    begin
      load_addr_reg <= load_addr_reg + CWS_LOAD_STEP;
    end
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Both decodes drop the upper address bits, which is what folds code and
  // table reads above 0FFFh back into the implemented words.
  assign in_prog_space = ~reg_addr[CWS_PROG_SPACE_BIT];
  assign data_index = reg_addr[CWS_IMPL_AW-1:0];
  assign fetch_index = pc_reg[CWS_IMPL_AW-1:0];

  cws_prog_mem #(
    .DEPTH(DEPTH),
    .WIDTH(CWS_WORD_W),
    .AW(CWS_IMPL_AW)
  ) u_prog_mem (
    .clk(clk),
    .wr_en(load_wr),
    .wr_addr(load_addr_reg),
    .wr_data(reg_wdata),
    .fetch_addr(fetch_index),
    .fetch_word(imem_word),
    .data_addr(data_index),
    .data_word(dmem_word)
  );

  cws_cal_rom #(
    .WORD8(CAL_WORD8),
    .WORD9(CAL_WORD9),
    .WORD10(CAL_WORD10),
    .WORD11(CAL_WORD11),
    .WORD12(CAL_WORD12)
  ) u_cal_rom (
    .addr(reg_addr),
    .word(cal_word),
    .hit(cal_hit)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Calibration words sit above the wrapped code range, so they are only
  // reachable here and never through instruction fetch.
  always_comb
  begin
    rdata_next = CWS_ZERO_WORD;
    if (in_prog_space)
    begin
      rdata_next = dmem_word;
    end
    else if (cal_hit)
    begin
      rdata_next = cal_word;
    end
    else
    begin
      case (reg_addr)
        CWS_CTRL_ADDR:
        begin
          rdata_next[CWS_CTRL_HOLD_BIT] = hold_reg;
        end
        CWS_STATUS_ADDR:
        begin
          rdata_next[CWS_PC_W-1:0] = pc_reg;
          rdata_next[CWS_STAT_WRAP_BIT] = wrap_reg;
        end
        CWS_LOAD_ADDR_ADDR:
        begin
          rdata_next[CWS_IMPL_AW-1:0] = load_addr_reg;
        end
        default:
        begin
          rdata_next = CWS_ZERO_WORD;
        end
      endcase
    end
  end

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_reg <= CWS_ZERO_WORD;
    end
    else if (reg_rd)
    begin
      rdata_reg <= rdata_next;
    end
    else
    begin
      rdata_reg <= CWS_ZERO_WORD;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      CWS_ST_BOOT:
      begin
        state_next = hold_reg ? CWS_ST_HOLD : CWS_ST_RUN;
      end
      CWS_ST_RUN:
      begin
        if (hold_reg)
        begin
          state_next = CWS_ST_HOLD;
        end
      end
      CWS_ST_HOLD:
      begin
        if (!hold_reg)
        begin
          state_next = CWS_ST_RUN;
        end
      end
      default:
      begin
        state_next = CWS_ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= CWS_ST_BOOT;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Fetches are refused while held so a loader can rewrite code safely.
  // The sequencer leaves HOLD one edge after the bit clears, so a core must
  // retry the first fetch that follows a release.
  assign fetch_go = fetch_req && (state_reg == CWS_ST_RUN) && !hold_reg;

  // ****************************************************************
  // Program counter
  // ****************************************************************
  // Restart beats interrupt, interrupt beats jump, jump beats increment.
  always_comb
  begin
    pc_next = pc_reg;
    if (restart_pulse)
    begin
      pc_next = CWS_RESET_VEC;
    end
    else if (irq_take)
    begin
      pc_next = CWS_IRQ_VEC;
    end
    else if (jump_req)
    begin
      pc_next = jump_target;
    end
    else if (fetch_go)
    begin
      pc_next = pc_reg + CWS_PC_STEP;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pc_reg <= CWS_RESET_VEC;
    end
    else
    begin
      pc_reg <= pc_next;
    end
  end

  // ****************************************************************
  // Fetch output
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fetch_reg <= '0;
      fetch_valid_reg <= 1'b0;
    end
    else
    begin
      fetch_valid_reg <= fetch_go;
      if (fetch_go)
      begin
        fetch_reg.pc <= pc_reg;
        fetch_reg.word <= imem_word;
      end
    end
  end

  // ****************************************************************
  // Wrap flag
  // ****************************************************************
  // Sticky: a fetch above the implemented range sets it, and a set in the
  // same cycle as a software clear wins so the event is not lost.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrap_reg <= 1'b0;
    end
    else if (fetch_go && pc_reg[CWS_PC_W-1])
    begin
      wrap_reg <= 1'b1;
    end
    else if (wrap_clear)
    begin
      wrap_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Each pin is a straight copy of a flip-flop, so no bus input reaches an
  // output within the same cycle.
  assign reg_rdata = rdata_reg;
  assign fetch_out = fetch_reg;
  assign fetch_valid = fetch_valid_reg;
  assign pc_out = pc_reg;

endmodule

// ---- bench/cws_chk.sv ----
`timescale 1ns/1ps
module cws_chk
  import cws_pkg::*;
#(
  parameter logic [13:0] CAL_WORD8 = CWS_CAL_ERASED,
  parameter logic [13:0] CAL_WORD9 = CWS_CAL_ERASED,
  parameter logic [13:0] CAL_WORD10 = CWS_CAL_ERASED,
  parameter logic [13:0] CAL_WORD11 = CWS_CAL_ERASED,
  parameter logic [13:0] CAL_WORD12 = CWS_CAL_ERASED
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] reg_addr,
  input wire logic [13:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [13:0] reg_rdata,
  input wire logic fetch_req,
  input wire logic irq_take,
  input wire logic jump_req,
  input wire logic [12:0] jump_target,
  input wire cws_fetch_t fetch_out,
  input wire logic fetch_valid,
  input wire logic [12:0] pc_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // Calibration words, unimplemented bits must read as zero
  // ****************************************************************
  AST_CAL8: assert property (reg_rd && reg_addr == 14'h2087
    |=> reg_rdata == (CAL_WORD8 & 14'h007f)) else $error("calibration word 8 read wrong");
  AST_CAL9: assert property (reg_rd && reg_addr == 14'h2088
    |=> reg_rdata == (CAL_WORD9 & 14'h1f0f)) else $error("calibration word 9 read wrong");
  AST_CAL10: assert property (reg_rd && reg_addr == 14'h2089
    |=> reg_rdata == (CAL_WORD10 & 14'h1f1f)) else $error("calibration word 10 read wrong");
  AST_CAL11: assert property (reg_rd && reg_addr == 14'h208a
    |=> reg_rdata == (CAL_WORD11 & 14'h0fff)) else $error("calibration word 11 read wrong");
  AST_CAL12: assert property (reg_rd && reg_addr == 14'h208b
    |=> reg_rdata == (CAL_WORD12 & 14'h007f)) else $error("calibration word 12 read wrong");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 14'h0000)
    else $error("read data present without a read");

  // ****************************************************************
  // Program counter and fetch
  // ****************************************************************
  AST_RESET_PC: assert property ($fell(rst) |-> pc_out == 13'h0000 && !fetch_valid)
    else $error("program counter not at reset vector");
  AST_IRQ_VEC: assert property (irq_take && !reg_wr && !$past(rst)
    |=> pc_out == 13'h0004) else $error("interrupt did not reach its vector");
  AST_RESTART: assert property (reg_wr && reg_addr == 14'h2000 && reg_wdata[1]
    |=> pc_out == 13'h0000) else $error("restart did not return to the reset vector");
  AST_JUMP: assert property (jump_req && !irq_take && !reg_wr && !$past(rst)
    |=> pc_out == jump_target) else $error("branch target not loaded");
  AST_FETCH_ORIGIN: assert property (fetch_valid
    |-> $past(fetch_req) && fetch_out.pc == $past(pc_out)) else $error("fetch without cause");
  AST_FETCH_STEP: assert property (fetch_valid && !$past(irq_take) && !$past(jump_req)
    && !$past(reg_wr) |-> pc_out == fetch_out.pc + 13'h0001)
    else $error("program counter did not step by one");
endmodule

bind cws_top cws_chk #(.CAL_WORD8(CAL_WORD8), .CAL_WORD9(CAL_WORD9),
  .CAL_WORD10(CAL_WORD10), .CAL_WORD11(CAL_WORD11), .CAL_WORD12(CAL_WORD12)) cws_chk_i (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_req(fetch_req), .irq_take(irq_take),
  .jump_req(jump_req), .jump_target(jump_target), .fetch_out(fetch_out),
  .fetch_valid(fetch_valid), .pc_out(pc_out));

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import cws_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] reg_addr = 14'h0000;
  logic [13:0] reg_wdata = 14'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [13:0] reg_rdata;
  logic fetch_req = 1'b0;
  logic irq_take = 1'b0;
  logic jump_req = 1'b0;
  logic [12:0] jump_target = 13'h0000;
  cws_fetch_t fetch_out;
  logic fetch_valid;
  logic [12:0] pc_out;
  logic [13:0] mem [0:4095];
  int num_errors = 0;
  int cmp_count = 0;

  `define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end

  always #2 clk = ~clk;

  // Words 8, 10 and 11 carry ones in every unimplemented bit, words 9 and 12 in some, so masking is visible.
  cws_top #(.CAL_WORD8(14'h3fab), .CAL_WORD9(14'h3a5c), .CAL_WORD10(14'h3fff),
    .CAL_WORD11(14'h3f80), .CAL_WORD12(14'h2aa5)) cws_top_i (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_req(fetch_req), .irq_take(irq_take),
    .jump_req(jump_req), .jump_target(jump_target), .fetch_out(fetch_out),
    .fetch_valid(fetch_valid), .pc_out(pc_out));

  // ****************************************************************
  // Bus and control tasks
  // ****************************************************************
  task automatic end_of_test();
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [13:0] a, input logic [13:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] a, output logic [13:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // The load pointer is twelve bits, so a load that runs past 0FFFh continues at 000h.
  task automatic load(input logic [11:0] a, input int n, input logic [13:0] base);
    wr(CWS_LOAD_ADDR_ADDR, {2'b00, a});
    for (int i = 0; i < n; i++)
    begin
      wr(CWS_LOAD_DATA_ADDR, base + 14'(i));
      mem[a + 12'(i)] = base + 14'(i);
    end
  endtask

  task automatic fetch_n(input int n, input logic [12:0] pc0);
    logic [12:0] p;
    @(posedge clk);
    fetch_req <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      if (i == n - 1)
        fetch_req <= 1'b0;
      #1 p = pc0 + 13'(i);
      `CHK("fetch_valid", 1'b1, fetch_valid)
      `CHK("fetch pc", p, fetch_out.pc)
      `CHK("fetch word", mem[p[11:0]], fetch_out.word)
      `CHK("pc_out", p + 13'h0001, pc_out)
    end
  endtask

  task automatic set_pc(input logic irq, input logic [12:0] t, input logic [12:0] e);
    @(posedge clk);
    irq_take <= irq;
    jump_req <= !irq;
    jump_target <= t;
    @(posedge clk);
    irq_take <= 1'b0;
    jump_req <= 1'b0;
    #1 `CHK("pc after load", e, pc_out)
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    do_reset();
    #1 `CHK("pc_out at reset", 13'h0000, pc_out)
    `CHK("fetch_valid at reset", 1'b0, fetch_valid)
  endtask

  task automatic t_cal();
    logic [13:0] want [5] = '{14'h002b, 14'h1a0c, 14'h1f1f, 14'h0f80, 14'h0025};
    logic [13:0] got [5];
    logic [13:0] d;
    for (int i = 0; i < 5; i++)
    begin
      wr(CAL_WORD_VOLT_AMP_OFFSET_ADDR + 14'(i), 14'h0000);
      rd(CAL_WORD_VOLT_AMP_OFFSET_ADDR + 14'(i), d);
      got[i] = d;
      `CHK("calibration word", want[i], d)
    end
    // Firmware picks each trim field out of its word before copying it across.
    `CHK("volt_amp_offset_trim", 7'h2b, got[0][6:0])
    `CHK("overvolt_ref_span_trim", 5'h1a, got[1][12:8])
    `CHK("sense_amp_gain_trim", 4'hc, got[1][3:0])
    `CHK("second_ref_span_trim", 5'h1f, got[2][12:8])
    `CHK("primary_ref_span_trim", 5'h1f, got[2][4:0])
    `CHK("analog_regulator_trim", 4'hf, got[3][11:8])
    `CHK("current_amp_offset_trim", 7'h25, got[4][6:0])
    rd(CAL_WORD_REGULATOR_AND_BUFFER_ADDR, d);
    `CHK("test mux offset", -128, $signed(d[7:0]))
    rd(14'h3000, d);
    `CHK("unmapped read", 14'h0000, d)
  endtask

  task automatic t_prog();
    logic [13:0] d;
    load(12'h000, 6, 14'h1100);
    load(12'hffe, 2, 14'h2200);
    rd(14'h0005, d);
    `CHK("data path word", mem[5], d)
    rd(14'h1ffe, d);
    `CHK("data path wrap", mem[12'hffe], d)
    do_reset();
    fetch_n(3, 13'h0000);
    set_pc(1'b1, 13'h0000, 13'h0004);
    fetch_n(2, 13'h0004);
    set_pc(1'b0, 13'h0ffe, 13'h0ffe);
    fetch_n(4, 13'h0ffe);
    set_pc(1'b0, 13'h1fff, 13'h1fff);
    fetch_n(2, 13'h1fff);
  endtask

  // Runs after the fetches past 0FFFh, so the wrap flag is expected set.
  task automatic t_ctrl();
    logic [13:0] d;
    rd(CWS_STATUS_ADDR, d);
    `CHK("status after wrap", 14'h2001, d)
    wr(CWS_STATUS_ADDR, 14'h2000);
    rd(CWS_STATUS_ADDR, d);
    `CHK("status after clear", 14'h0001, d)
    wr(CWS_CTRL_ADDR, 14'h0001);
    rd(CWS_CTRL_ADDR, d);
    `CHK("hold bit", 14'h0001, d)
    @(posedge clk);
    fetch_req <= 1'b1;
    repeat (3)
    begin
      @(posedge clk);
      #1 `CHK("fetch_valid while held", 1'b0, fetch_valid)
    end
    @(posedge clk);
    fetch_req <= 1'b0;
    #1 `CHK("pc_out while held", 13'h0001, pc_out)
    wr(CWS_CTRL_ADDR, 14'h0002);
    #1 `CHK("pc after restart", 13'h0000, pc_out)
    wr(CWS_LOAD_ADDR_ADDR, 14'h0abc);
    rd(CWS_LOAD_ADDR_ADDR, d);
    `CHK("load pointer", 14'h0abc, d)
    fetch_n(2, 13'h0000);
  endtask

  initial
  begin
    t_reset();
    t_cal();
    t_prog();
    t_ctrl();
    end_of_test();
  end

  // The whole sequence needs under 150 cycles; this 5000-cycle limit leaves ample margin.
  initial
  begin
    #20000;
    num_errors++;
    end_of_test();
  end
endmodule
